// ---- rtl/mbf_pkg.sv ----
// Package for the frame function handler: codes, limits and carriers
package mbf_pkg;
   localparam logic [7:0] FC_READ = 8'h03;
   localparam logic [7:0] FC_WR1 = 8'h06;
   localparam logic [7:0] FC_DIAG = 8'h08;
   localparam logic [7:0] FC_WRN = 8'h10;
   localparam logic [7:0] FC_LOG = 8'h46;
   localparam logic [7:0] FC_EXC = 8'h80;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_ADDR = 8'h02;
   localparam logic [7:0] EXC_DATA = 8'h03;
   localparam logic [7:0] ADDR_BCAST = 8'h00;
   localparam logic [15:0] SUB_ECHO = 16'h0000;
   localparam logic [15:0] QTY_MAX = 16'h007d;
   localparam logic [7:0] BC_MIN = 8'h02;
   localparam logic [7:0] BC_MAX = 8'hfa;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   localparam int BUF_DEPTH = 512;

   // Byte stream beat
   typedef struct packed {
      logic [7:0] data;
      logic last;
   } mbf_byte_s;

   // Holding register write strobe
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] data;
   } mbf_wr_s;
endpackage

// ---- rtl/mbf_mem.sv ----
// Frame byte store with registered read data
`timescale 1ns/1ps
module mbf_mem #(
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [7:0] rdata
);
   logic [7:0] mem [DEPTH];

   if (DEPTH > (1 << AW)) $error("DEPTH too large for AW");

   always_ff @(posedge clk)
   begin
      if (we) mem[waddr] <= wdata;
      rdata <= mem[raddr];
   end
endmodule

// ---- rtl/mbf_handler.sv ----
// Server handler for diagnostics echo, multiple write and access log
// Summary of operation
// - Sub-function zero diagnostics echoes whole query
// - Address zero ignored for diagnostics, log
// - Any diagnostics data value echoed unchanged
// - Function 10 hex writes consecutive registers
// - Broadcast multiple write performed, no reply
// - Start field is register minus 40001
// - Quantity limited to 125 registers
// - Byte count equals twice quantity
// - Values high byte first, ascending order
// - Write reply repeats address, function, start, quantity
// - Function 46 hex returns logged start, count
// - Log only 03, 06, 10; else zero
// - Logged start reported high byte first
// - Logged count reported high byte first
// - Illegal function/address/data gives exception reply
// - Errored or overlong frames get no reply
// - Partial writable range gives no exception
`timescale 1ns/1ps
module mbf_handler #(
   parameter logic [7:0] OWN_ADDR = 8'h01
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire mbf_pkg::mbf_byte_s rx_beat,
   input wire logic rx_valid,
   input wire logic rx_err,
   output logic rx_ready,
   output mbf_pkg::mbf_byte_s tx_beat,
   output logic tx_valid,
   input wire logic tx_ready,
   output mbf_pkg::mbf_wr_s wr_req,
   output logic wr_valid,
   input wire logic wr_ok,
   input wire logic [15:0] ext_start,
   input wire logic [15:0] ext_count,
   input wire logic [7:0] ext_func,
   input wire logic ext_done
);
   typedef enum logic [3:0] {
      ST_RX = 4'b0001,
      ST_EXEC = 4'b0010,
      ST_WR = 4'b0100,
      ST_TX = 4'b1000
   } mbf_state_e;

   mbf_state_e state_q;
   logic [8:0] cnt_q, len_q, rd_q;
   logic [15:0] crc_q, start_q, qty_q, wcnt_q, wok_q, lstart_q, lcount_q;
   logic [7:0] hi_q, exc_q;
   logic [7:0] resp_q [8];
   logic [7:0] rlen_q, tix_q;
   logic drop_q, bcast_q, ok_any_q, rd_pend_q;
   logic [15:0] crc_out_q;
   logic [7:0] mem_rdata;
   if (OWN_ADDR == mbf_pkg::ADDR_BCAST) $error("OWN_ADDR must not be the broadcast address");

   // CRC update per byte
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ mbf_pkg::CRC_POLY) : (r >> 1);
      return r;
   endfunction

   wire rx_take = rx_valid && (state_q == ST_RX);
   wire [7:0] rx_b = rx_beat.data;
   wire [7:0] b0, b1;
   assign b0 = resp_q[0];
   assign b1 = resp_q[1];
   wire [15:0] f23 = {resp_q[2], resp_q[3]};
   wire [15:0] f45 = {resp_q[4], resp_q[5]};
   wire is_bcast = (b0 == mbf_pkg::ADDR_BCAST);
   wire for_us = (b0 == OWN_ADDR) || is_bcast;
   wire crc_good = (crc_q == 16'h0000);
   wire known_fc = (b1 == mbf_pkg::FC_DIAG) || (b1 == mbf_pkg::FC_WRN)
                   || (b1 == mbf_pkg::FC_LOG);
   wire qty_bad = (f45 == 16'h0000) || (f45 > mbf_pkg::QTY_MAX);
   wire bc_bad = (len_q < 9'd7) || (hi_q != {f45[6:0], 1'b0})
                 || (hi_q < mbf_pkg::BC_MIN) || (hi_q > mbf_pkg::BC_MAX);
   wire wr_step = (state_q == ST_WR) && rd_pend_q;
   wire tx_fire = tx_valid && tx_ready;
   wire [7:0] tx_byte = (tix_q < rlen_q) ? resp_q[tix_q[2:0]]
                        : ((tix_q == rlen_q) ? crc_out_q[7:0] : crc_out_q[15:8]);
   wire [15:0] crc_tx_next = crc_step(crc_out_q, tx_byte);

   assign rx_ready = (state_q == ST_RX);
   assign tx_valid = (state_q == ST_TX);
   assign tx_beat.data = tx_byte;
   assign tx_beat.last = (tix_q == rlen_q + 8'd1);
   assign wr_valid = wr_step;
   assign wr_req.addr = start_q + wcnt_q;
   assign wr_req.data = {hi_q, mem_rdata};

   // Payload bytes beyond the fixed header are kept for the write phase
   mbf_mem #(.DEPTH(mbf_pkg::BUF_DEPTH), .AW(9)) u_buf (
      .clk(clk),
      .we(rx_take),
      .waddr(cnt_q),
      .wdata(rx_b),
      .raddr(rd_q),
      .rdata(mem_rdata)
   );

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= ST_RX;
         cnt_q <= 9'h000;
         len_q <= 9'h000;
         crc_q <= mbf_pkg::CRC_INIT;
         drop_q <= 1'b0;
         hi_q <= 8'h00;
         exc_q <= 8'h00;
         rd_q <= 9'h007;
         rd_pend_q <= 1'b0;
         start_q <= 16'h0000;
         qty_q <= 16'h0000;
         wcnt_q <= 16'h0000;
         wok_q <= 16'h0000;
         ok_any_q <= 1'b0;
         bcast_q <= 1'b0;
         lstart_q <= 16'h0000;
         lcount_q <= 16'h0000;
         rlen_q <= 8'h00;
         tix_q <= 8'h00;
         crc_out_q <= mbf_pkg::CRC_INIT;
         for (int i = 0; i < 8; i++) resp_q[i] <= 8'h00;
      end
      else
      begin
         case (state_q)
            ST_RX:
            begin
               rd_q <= 9'd7;
               if (rx_take)
               begin
                  crc_q <= crc_step(crc_q, rx_b);
                  if (cnt_q < 9'd8) resp_q[cnt_q[2:0]] <= rx_b;
                  if (cnt_q == 9'd6) hi_q <= rx_b;
                  if (rx_err || cnt_q == 9'h1ff) drop_q <= 1'b1;
                  cnt_q <= cnt_q + 9'd1;
                  if (rx_beat.last)
                  begin
                     len_q <= cnt_q + 9'd1;
                     state_q <= ST_EXEC;
                  end
               end
            end
            ST_EXEC:
            begin
               cnt_q <= 9'h000;
               crc_q <= mbf_pkg::CRC_INIT;
               drop_q <= 1'b0;
               bcast_q <= is_bcast;
               tix_q <= 8'h00;
               crc_out_q <= mbf_pkg::CRC_INIT;
               state_q <= ST_RX;
               // Too short, corrupted or not addressed: silent
               if (!drop_q && crc_good && len_q >= 9'd4 && for_us)
               begin
                  if (!is_bcast || b1 == mbf_pkg::FC_WRN) {lstart_q, lcount_q} <= 32'h00000000;
                  if (!known_fc)
                  begin
                     if (!is_bcast)
                     begin
                        resp_q[1] <= b1 | mbf_pkg::FC_EXC;
                        resp_q[2] <= mbf_pkg::EXC_FUNC;
                        rlen_q <= 8'd3;
                        state_q <= ST_TX;
                     end
                  end
                  else if (b1 == mbf_pkg::FC_WRN)
                  begin
                     if (qty_bad || bc_bad || len_q != {1'b0, hi_q} + 9'd9)
                     begin
                        if (!is_bcast)
                        begin
                           resp_q[1] <= b1 | mbf_pkg::FC_EXC;
                           resp_q[2] <= mbf_pkg::EXC_DATA;
                           rlen_q <= 8'd3;
                           state_q <= ST_TX;
                        end
                     end
                     else
                     begin
                        start_q <= f23;
                        qty_q <= f45;
                        wcnt_q <= 16'h0000;
                        wok_q <= 16'h0000;
                        ok_any_q <= 1'b0;
                        rd_q <= 9'd8;
                        state_q <= ST_WR;
                     end
                  end
                  else if (!is_bcast)
                  begin
                     if (b1 == mbf_pkg::FC_DIAG)
                     begin
                        rlen_q <= 8'd6;
                        if (f23 != mbf_pkg::SUB_ECHO || len_q != 9'd8)
                        begin
                           resp_q[1] <= b1 | mbf_pkg::FC_EXC;
                           resp_q[2] <= (f23 != mbf_pkg::SUB_ECHO) ? mbf_pkg::EXC_FUNC
                                        : mbf_pkg::EXC_DATA;
                           rlen_q <= 8'd3;
                        end
                        state_q <= ST_TX;
                     end
                     else
                     begin
                        resp_q[2] <= lstart_q[15:8];
                        resp_q[3] <= lstart_q[7:0];
                        resp_q[4] <= lcount_q[15:8];
                        resp_q[5] <= lcount_q[7:0];
                        rlen_q <= 8'd6;
                        state_q <= ST_TX;
                     end
                  end
               end
            end
            ST_WR:
            begin
               // Two-beat read: high byte latched, low byte from memory
               if (!rd_pend_q)
               begin
                  hi_q <= mem_rdata;
                  rd_q <= rd_q + 9'd1;
                  rd_pend_q <= 1'b1;
               end
               else
               begin
                  rd_pend_q <= 1'b0;
                  rd_q <= rd_q + 9'd1;
                  wcnt_q <= wcnt_q + 16'd1;
                  if (wr_ok)
                  begin
                     ok_any_q <= 1'b1;
                     wok_q <= wok_q + 16'd1;
                  end
                  if (wcnt_q + 16'd1 == qty_q)
                  begin
                     lstart_q <= start_q;
                     lcount_q <= wok_q + {15'h0000, wr_ok};
                     rlen_q <= 8'd6;
                     if (!(ok_any_q || wr_ok))
                     begin
                        resp_q[1] <= mbf_pkg::FC_WRN | mbf_pkg::FC_EXC;
                        resp_q[2] <= mbf_pkg::EXC_ADDR;
                        rlen_q <= 8'd3;
                     end
                     state_q <= bcast_q ? ST_RX : ST_TX;
                  end
               end
            end
            ST_TX:
            begin
               if (tx_fire)
               begin
                  if (tix_q < rlen_q) crc_out_q <= crc_tx_next;
                  tix_q <= tix_q + 8'd1;
                  if (tx_beat.last) state_q <= ST_RX;
               end
            end
            default: state_q <= ST_RX;
         endcase
         // Reports from the 03 and 06 units come last so they win over a clear
         if (ext_done)
         begin
            if ((ext_func == mbf_pkg::FC_READ) || (ext_func == mbf_pkg::FC_WR1))
            begin
               lstart_q <= ext_start;
               lcount_q <= ext_count;
            end
            else
            begin
               lstart_q <= 16'h0000;
               lcount_q <= 16'h0000;
            end
         end
      end
   end
endmodule

// ---- bench/mbf_handler_properties.sv ----
// Port-level properties of the frame function handler
`timescale 1ns/1ps
module mbf_handler_properties #(
   parameter logic [7:0] OWN_ADDR = 8'h01
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire mbf_pkg::mbf_byte_s rx_beat,
   input wire logic rx_valid,
   input wire logic rx_err,
   input wire logic rx_ready,
   input wire mbf_pkg::mbf_byte_s tx_beat,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire mbf_pkg::mbf_wr_s wr_req,
   input wire logic wr_valid
);
   logic first_q, bc_q, err_q, quiet_q, have_q;
   logic [15:0] last_q;
   wire acc = rx_valid && rx_ready;
   wire bc_now = first_q ? (rx_beat.data == mbf_pkg::ADDR_BCAST) : bc_q;
   // Silent span lasts until the receiver is idle again
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         first_q <= 1'b1;
         bc_q <= 1'b0;
         err_q <= 1'b0;
         quiet_q <= 1'b0;
         have_q <= 1'b0;
         last_q <= 16'h0000;
      end
      else
      begin
         if (acc)
         begin
            first_q <= rx_beat.last;
            bc_q <= bc_now;
            err_q <= !rx_beat.last && (err_q || rx_err);
         end
         quiet_q <= (acc && rx_beat.last && (bc_now || err_q || rx_err)) || (quiet_q && !rx_ready);
         have_q <= wr_valid || (have_q && !rx_ready);
         if (wr_valid)
            last_q <= wr_req.addr;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_end;
      rx_valid && rx_ready && rx_beat.last;
   endsequence
   sequence s_stall;
      tx_valid && !tx_ready;
   endsequence
   AST_TX_HOLD: assert property (s_stall |=> tx_valid && $stable(tx_beat))
      else $error("reply byte changed while stalled");
   AST_BUSY_TX: assert property (tx_valid |-> !rx_ready)
      else $error("bytes taken while replying");
   AST_BUSY_WR: assert property (wr_valid |-> !rx_ready)
      else $error("bytes taken while writing");
   AST_WR_ASCEND: assert property (wr_valid && have_q |-> wr_req.addr == last_q + 16'h0001)
      else $error("write addresses not ascending");
   AST_QUIET: assert property (quiet_q |-> !tx_valid)
      else $error("reply to broadcast or errored frame");
   AST_REPLY_ADDR: assert property ($rose(tx_valid) |-> tx_beat.data == OWN_ADDR)
      else $error("reply does not start with own address");
   AST_TX_END: assert property (tx_valid && tx_ready && tx_beat.last |=> !tx_valid)
      else $error("reply runs past its check code");
   AST_EXEC_GAP: assert property (s_end |=> !tx_valid)
      else $error("reply without execution cycle");
endmodule
bind mbf_handler mbf_handler_properties #(.OWN_ADDR(OWN_ADDR)) u_props (
   .clk(clk), .arst_n(arst_n), .rx_beat(rx_beat), .rx_valid(rx_valid), .rx_err(rx_err),
   .rx_ready(rx_ready), .tx_beat(tx_beat), .tx_valid(tx_valid), .tx_ready(tx_ready),
   .wr_req(wr_req), .wr_valid(wr_valid));

// ---- bench/mbf_client.sv ----
// Client-side model: reply sink with stalls and register acknowledge
`timescale 1ns/1ps
module mbf_client (
   input wire logic clk,
   input wire mbf_pkg::mbf_byte_s tx_beat,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire mbf_pkg::mbf_wr_s wr_req,
   input wire logic wr_valid,
   output logic wr_ok,
   input wire logic [1:0] deny
);
   logic [7:0] rsp[$];
   logic [31:0] wrs[$];
   // Deny 1: nothing writable; deny 2: odd registers absent
   assign wr_ok = wr_valid && (deny == 2'h0 || (deny == 2'h2 && !wr_req.addr[0]));
   initial tx_ready = 1'b0;
   always @(posedge clk)
   begin
      if (tx_valid && tx_ready)
         rsp.push_back(tx_beat.data);
      if (wr_valid)
         wrs.push_back(wr_req);
      tx_ready <= ($urandom % 3) != 0;
   end
endmodule

// ---- bench/mbf_handler_tb_top.sv ----
// Self-checking bench for the frame function handler
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
   $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module mbf_handler_tb_top;
   typedef logic [7:0] mbf_bq_t[$];
   localparam logic [7:0] ME = 8'h01;
   logic clk = 1'b0, arst_n = 1'b0, rx_valid = 1'b0, rx_err = 1'b0, ext_done = 1'b0;
   mbf_pkg::mbf_byte_s rx_beat = '0;
   logic [7:0] ext_func = 8'h00;
   logic [15:0] ext_start = 16'h0000, ext_count = 16'h0000;
   logic [1:0] deny = 2'h0;
   logic rx_ready, tx_valid, tx_ready, wr_valid, wr_ok;
   mbf_pkg::mbf_byte_s tx_beat;
   mbf_pkg::mbf_wr_s wr_req;
   int miscompares = 0, tests_run = 0;
   always #50 clk = ~clk;
   mbf_handler #(.OWN_ADDR(ME)) dut (.clk(clk), .arst_n(arst_n), .rx_beat(rx_beat),
      .rx_valid(rx_valid), .rx_err(rx_err), .rx_ready(rx_ready), .tx_beat(tx_beat),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .wr_req(wr_req), .wr_valid(wr_valid),
      .wr_ok(wr_ok), .ext_start(ext_start), .ext_count(ext_count), .ext_func(ext_func),
      .ext_done(ext_done));
   mbf_client cli (.clk(clk), .tx_beat(tx_beat), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .wr_req(wr_req), .wr_valid(wr_valid), .wr_ok(wr_ok), .deny(deny));
   function automatic mbf_bq_t crcd(mbf_bq_t f);
      logic [15:0] c;
      c = mbf_pkg::CRC_INIT;
      foreach (f[i])
      begin
         c ^= {8'h00, f[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ mbf_pkg::CRC_POLY : c >> 1;
      end
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
      return f;
   endfunction
   function automatic mbf_bq_t wfr(logic [7:0] a, logic [15:0] s, logic [15:0] n, logic [7:0] b);
      mbf_bq_t f;
      f = '{a, mbf_pkg::FC_WRN, s[15:8], s[7:0], n[15:8], n[7:0], b};
      repeat (b) f.push_back(8'($urandom));
      return f;
   endfunction
   function automatic mbf_bq_t lexp(logic [15:0] s, logic [15:0] n);
      return '{ME, mbf_pkg::FC_LOG, s[15:8], s[7:0], n[15:8], n[7:0]};
   endfunction
   task automatic run(mbf_bq_t q, mbf_bq_t e, bit bad, bit err);
      mbf_bq_t f;
      int n;
      f = crcd(q);
      f[f.size() - 1] ^= {7'h00, bad};
      cli.rsp.delete();
      cli.wrs.delete();
      foreach (f[i])
      begin
         rx_valid <= 1'b1;
         rx_beat <= {f[i], 1'(i == f.size() - 1)};
         rx_err <= err;
         @(posedge clk);
         while (rx_ready !== 1'b1) @(posedge clk);
      end
      rx_valid <= 1'b0;
      rx_err <= 1'b0;
      if (e.size() != 0)
         e = crcd(e);
      n = 0;
      // Silent cases wait out the full span before the next query
      while (n < 700 && (e.size() == 0 || cli.rsp.size() < e.size()))
      begin
         @(posedge clk);
         n++;
      end
      repeat (20) @(posedge clk);
      `CHK(cli.rsp.size(), e.size())
      foreach (e[i]) `CHK(cli.rsp[i], e[i])
   endtask
   task automatic chk_wr(mbf_bq_t f);
      `CHK(cli.wrs.size(), f[6] / 2)
      foreach (cli.wrs[i])
         `CHK(cli.wrs[i], {{f[2], f[3]} + 16'(i), f[7 + 2 * i], f[8 + 2 * i]})
   endtask
   task automatic test_done();
      $display("checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge clk);
      miscompares++;
      test_done();
   end
   initial
   begin
      mbf_bq_t f, lq;
      logic [15:0] d, s, n;
      void'($urandom(28));
      lq = '{ME, mbf_pkg::FC_LOG};
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 6; i++)
      begin
         d = i == 0 ? 16'h0000 : i == 1 ? 16'hffff : 16'($urandom);
         f = '{ME, mbf_pkg::FC_DIAG, 8'h00, 8'h00, d[15:8], d[7:0]};
         run(f, f, 1'b0, 1'b0);
      end
      run(lq, lexp(0, 0), 1'b0, 1'b0);
      run(f, '{}, 1'b1, 1'b0);
      run(f, '{}, 1'b0, 1'b1);
      f[0] = mbf_pkg::ADDR_BCAST;
      run(f, '{}, 1'b0, 1'b0);
      $display("test diagnostics finished");
      for (int k = 0; k < 3; k++)
      begin
         n = k == 0 ? 16'h0001 : k == 1 ? mbf_pkg::QTY_MAX : 16'(2 + $urandom % 6);
         s = 16'($urandom % 16'hff00);
         f = wfr(ME, s, n, 8'(2 * n));
         run(f, f[0:5], 1'b0, 1'b0);
         chk_wr(f);
         run(lq, lexp(s, n), 1'b0, 1'b0);
         run(lq, lexp(0, 0), 1'b0, 1'b0);
      end
      f = wfr(mbf_pkg::ADDR_BCAST, 16'h0010, 16'h0003, 8'h06);
      run(f, '{}, 1'b0, 1'b0);
      chk_wr(f);
      $display("test writes finished");
      for (int k = 0; k < 3; k++)
      begin
         s = 16'($urandom);
         d = 16'($urandom);
         ext_func <= k == 0 ? mbf_pkg::FC_READ : k == 1 ? mbf_pkg::FC_WR1 : 8'h2b;
         ext_start <= s;
         ext_count <= d;
         ext_done <= 1'b1;
         @(posedge clk);
         ext_done <= 1'b0;
         if (k == 2)
            {s, d} = 32'h0;
         run(lq, lexp(s, d), 1'b0, 1'b0);
      end
      $display("test access log finished");
      for (int k = 0; k < 6; k++)
      begin
         case (k)
            0: f = '{ME, 8'h2b, 8'h00, 8'h01};
            1: f = '{ME, mbf_pkg::FC_DIAG, 8'h00, 8'h01, 8'h12, 8'h34};
            2: f = wfr(ME, 16'h0000, 16'h007e, 8'hfc);
            3: f = wfr(ME, 16'h0000, 16'h0002, 8'h05);
            4: f = wfr(ME, 16'h0000, 16'h0000, 8'h00);
            default: f = wfr(ME, 16'h0004, 16'h0002, 8'h04);
         endcase
         deny <= k == 5 ? 2'h1 : 2'h0;
         run(f, '{ME, f[1] | mbf_pkg::FC_EXC, k < 2 ? mbf_pkg::EXC_FUNC : k < 5 ?
            mbf_pkg::EXC_DATA : mbf_pkg::EXC_ADDR}, 1'b0, 1'b0);
      end
      deny <= 2'h2;
      f = wfr(ME, 16'h0020, 16'h0003, 8'h06);
      run(f, f[0:5], 1'b0, 1'b0);
      chk_wr(f);
      run(lq, lexp(16'h0020, 16'h0002), 1'b0, 1'b0);
      deny <= 2'h0;
      $display("test exceptions finished");
      test_done();
   end
endmodule
